// [slc_lamp_ctrl.sv]
`timescale 1ns/1ps
`include "slc_defines.svh"
module slc_lamp_ctrl #(
  parameter int ADC_W = `SLC_ADC_W,
  parameter int AVG_SHIFT = `SLC_AVG_SHIFT,
  parameter int DEBOUNCE_CYC = `SLC_DEBOUNCE_CYC,
  parameter int BLINK_CYC = `SLC_BLINK_CYC,
  parameter logic [ADC_W-1:0] INITIAL_DUTY = ADC_W'(`SLC_INITIAL_DUTY),
  parameter logic [ADC_W-1:0] FIRST_DIM_DUTY = `SLC_FIRST_DIM_DUTY,
  parameter logic [ADC_W-1:0] SECOND_DIM_DUTY = `SLC_SECOND_DIM_DUTY,
  parameter logic [ADC_W-1:0] LOW_BATT_TH = `SLC_LOW_BATT_TH,
  parameter logic [ADC_W-1:0] OVERCHARGE_TH = `SLC_OVERCHARGE_TH,
  parameter logic [ADC_W-1:0] PHONE_CUT_TH = `SLC_PHONE_CUT_TH,
  parameter bit PHONE_ACTIVE_HIGH = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic adc_done_in,
  input wire logic adc_chan_in,
  input wire logic [ADC_W-1:0] adc_data_in,
  input wire logic button_in,
  input wire logic led_open_in,
  input wire logic charge_source_in,
  input wire logic light_on_cmd_in,
  input wire logic light_off_cmd_in,
  input wire logic charge_switch_on_in,
  input wire logic charge_switch_off_in,
  input wire logic phone_charge_on_in,
  input wire logic phone_charge_off_in,
  input wire logic charge_indicator_on_in,
  input wire logic charge_indicator_off_in,
  input wire logic low_battery_indicator_on_in,
  input wire logic low_battery_indicator_off_in,
  output logic pwm_out,
  output logic lamp_on_out,
  output logic open_fault_out,
  output logic [ADC_W-1:0] duty_out,
  output logic [ADC_W-1:0] battery_volt_out,
  output logic battery_valid_out,
  output logic charge_switch_out,
  output logic phone_charge_enable_out,
  output logic charge_indicator_out,
  output logic low_battery_indicator_out
);
  localparam logic [ADC_W-1:0] DUTY_MAX = '1;

  // Each lamp state maps to its own duty constant; extra dim steps extend the enum here.
  function automatic logic [ADC_W-1:0] duty_of(slc_pkg::slc_lamp_t st);
    case (st)
      slc_pkg::SLC_LAMP_FULL: duty_of = INITIAL_DUTY;
      slc_pkg::SLC_LAMP_DIM1: duty_of = FIRST_DIM_DUTY;
      slc_pkg::SLC_LAMP_DIM2: duty_of = SECOND_DIM_DUTY;
      default: duty_of = `SLC_DUTY_RST;
    endcase
  endfunction

  function automatic slc_pkg::slc_lamp_t step_of(slc_pkg::slc_lamp_t st);
    case (st)
      slc_pkg::SLC_LAMP_OFF: step_of = slc_pkg::SLC_LAMP_FULL;
      slc_pkg::SLC_LAMP_FULL: step_of = slc_pkg::SLC_LAMP_DIM1;
      slc_pkg::SLC_LAMP_DIM1: step_of = slc_pkg::SLC_LAMP_DIM2;
      default: step_of = slc_pkg::SLC_LAMP_OFF;
    endcase
  endfunction

  slc_pkg::slc_lamp_t lamp_reg;
  slc_pkg::slc_lamp_t lamp_next;
  logic [ADC_W-1:0] duty_reg;
  logic [ADC_W-1:0] duty_next;
  logic [ADC_W-1:0] target_reg;
  logic [ADC_W-1:0] pwm_cnt_reg;
  logic pwm_reg;
  logic fault_reg;
  logic lowbat_reg;
  logic batt_valid_reg;
  logic [ADC_W-1:0] batt_reg;
  logic charge_auto_reg;
  logic phone_auto_reg;
  logic [3:0] en_reg;
  logic [3:0] en_next;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic chg_sw_reg;
  logic phone_reg;
  logic chg_ind_reg;
  logic low_ind_reg;
  logic lamp_on_reg;

  logic press;
  logic open_lvl;
  logic source_lvl;
  logic cur_valid;
  logic [ADC_W-1:0] cur_avg;
  logic bat_valid;
  logic [ADC_W-1:0] bat_avg;

  slc_in_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_button (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(button_in),
    .level_out(),
    .rise_out(press)
  );

  slc_in_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_open (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(led_open_in),
    .level_out(open_lvl),
    .rise_out()
  );

  slc_in_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_source (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(charge_source_in),
    .level_out(source_lvl),
    .rise_out()
  );

  // Every completed conversion is steered to its averager in the cycle it arrives.
  wire cur_sample = adc_done_in && (adc_chan_in == `SLC_CHAN_CURRENT);
  wire bat_sample = adc_done_in && (adc_chan_in == `SLC_CHAN_BATTERY);

  slc_averager #(.W(ADC_W), .SHIFT(AVG_SHIFT)) u_cur_avg (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(cur_sample),
    .sample_in(adc_data_in),
    .avg_valid_out(cur_valid),
    .avg_out(cur_avg)
  );

  slc_averager #(.W(ADC_W), .SHIFT(AVG_SHIFT)) u_bat_avg (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(bat_sample),
    .sample_in(adc_data_in),
    .avg_valid_out(bat_valid),
    .avg_out(bat_avg)
  );

  // Protection cuts beat commands, and commands beat the button.
  wire lit = lamp_reg != slc_pkg::SLC_LAMP_OFF;
  wire open_cut = lit && open_lvl;
  wire cut_now = open_cut || lowbat_reg;
  assign lamp_next = cut_now ? slc_pkg::SLC_LAMP_OFF :
                     light_off_cmd_in ? slc_pkg::SLC_LAMP_OFF :
                     light_on_cmd_in ? slc_pkg::SLC_LAMP_FULL :
                     press ? step_of(lamp_reg) : lamp_reg;
  wire level_load = lamp_next != lamp_reg;

  // The loop only moves the duty one step per average; a lamp level change loads the new target duty at once.
  wire raise = cur_valid && lit && (cur_avg < target_reg) && (duty_reg != DUTY_MAX);
  wire lower = cur_valid && lit && (cur_avg > target_reg) && (duty_reg != '0);
  assign duty_next = level_load ? duty_of(lamp_next) :
                     raise ? ADC_W'(duty_reg + 1'b1) :
                     lower ? ADC_W'(duty_reg - 1'b1) : duty_reg;

  // Battery decisions are remade on each new average; before the first one the lamp is not cut, but charging and the phone output stay off.
  wire bat_low = bat_avg < LOW_BATT_TH;
  wire bat_full = bat_avg >= OVERCHARGE_TH;
  wire charging = charge_auto_reg && source_lvl;
  wire full_now = source_lvl && batt_valid_reg && (batt_reg >= OVERCHARGE_TH);
  wire chg_ind_auto = full_now || (charging && blink_reg);
  wire blink_wrap = blink_cnt_reg >= 32'(BLINK_CYC - 1);

  // Off wins over on when both arrive together, favouring the safe state.
  assign en_next = {
    (en_reg[`SLC_EN_LOW_IND] || low_battery_indicator_on_in) && !low_battery_indicator_off_in,
    (en_reg[`SLC_EN_CHG_IND] || charge_indicator_on_in) && !charge_indicator_off_in,
    (en_reg[`SLC_EN_PHONE] || phone_charge_on_in) && !phone_charge_off_in,
    (en_reg[`SLC_EN_CHG_SW] || charge_switch_on_in) && !charge_switch_off_in
  };

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lamp_reg <= slc_pkg::SLC_LAMP_OFF;
      duty_reg <= `SLC_DUTY_RST;
      target_reg <= `SLC_DUTY_RST;
      fault_reg <= 1'b0;
      lamp_on_reg <= 1'b0;
    end else begin
      lamp_reg <= lamp_next;
      lamp_on_reg <= lamp_next != slc_pkg::SLC_LAMP_OFF;
      duty_reg <= duty_next;
      target_reg <= duty_of(lamp_next);
      if (open_cut) begin
        fault_reg <= 1'b1;
      end else if (level_load && lamp_next != slc_pkg::SLC_LAMP_OFF) begin
        fault_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pwm_cnt_reg <= '0;
      pwm_reg <= 1'b0;
    end else begin
      pwm_cnt_reg <= ADC_W'(pwm_cnt_reg + 1'b1);
      pwm_reg <= lit && !cut_now && (pwm_cnt_reg < duty_reg);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      batt_reg <= '0;
      batt_valid_reg <= 1'b0;
      lowbat_reg <= 1'b0;
      charge_auto_reg <= 1'b0;
      phone_auto_reg <= 1'b0;
    end else if (bat_valid) begin
      batt_reg <= bat_avg;
      batt_valid_reg <= 1'b1;
      lowbat_reg <= bat_low;
      charge_auto_reg <= !bat_full;
      phone_auto_reg <= bat_avg >= PHONE_CUT_TH;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
      en_reg <= `SLC_ENABLES_RST;
      chg_sw_reg <= 1'b0;
      phone_reg <= !PHONE_ACTIVE_HIGH;
      chg_ind_reg <= 1'b0;
      low_ind_reg <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_wrap ? 32'h0 : 32'(blink_cnt_reg + 32'h1);
      if (blink_wrap) begin
        blink_reg <= !blink_reg;
      end
      en_reg <= en_next;
      chg_sw_reg <= charging && en_reg[`SLC_EN_CHG_SW];
      phone_reg <= (phone_auto_reg && en_reg[`SLC_EN_PHONE]) ~^ PHONE_ACTIVE_HIGH;
      chg_ind_reg <= chg_ind_auto && en_reg[`SLC_EN_CHG_IND];
      low_ind_reg <= lowbat_reg && en_reg[`SLC_EN_LOW_IND];
    end
  end

  assign pwm_out = pwm_reg;
  assign lamp_on_out = lamp_on_reg;
  assign open_fault_out = fault_reg;
  assign duty_out = duty_reg;
  assign battery_volt_out = batt_reg;
  assign battery_valid_out = batt_valid_reg;
  assign charge_switch_out = chg_sw_reg;
  assign phone_charge_enable_out = phone_reg;
  assign charge_indicator_out = chg_ind_reg;
  assign low_battery_indicator_out = low_ind_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_duty_raise_step: assert property (
    (raise && !level_load) |=> duty_out == $past(duty_out) + 1'b1)
    else $error("duty did not rise by one on low current");
  a_duty_lower_step: assert property (
    (lower && !level_load) |=> duty_out == $past(duty_out) - 1'b1)
    else $error("duty did not fall by one on high current");
  a_first_press_on: assert property (
    (press && !lit && !cut_now && !light_off_cmd_in && !light_on_cmd_in)
      |=> lamp_reg == slc_pkg::SLC_LAMP_FULL && duty_out == INITIAL_DUTY)
    else $error("first press did not light at initial duty");
  a_second_press_dim: assert property (
    (press && lamp_reg == slc_pkg::SLC_LAMP_FULL && !cut_now && !light_off_cmd_in
      && !light_on_cmd_in) |=> duty_out == FIRST_DIM_DUTY)
    else $error("second press did not apply first dim duty");
  a_third_press_dim: assert property (
    (press && lamp_reg == slc_pkg::SLC_LAMP_DIM1 && !cut_now && !light_off_cmd_in
      && !light_on_cmd_in) |=> duty_out == SECOND_DIM_DUTY)
    else $error("third press did not apply second dim duty");
  a_fourth_press_off: assert property (
    (press && lamp_reg == slc_pkg::SLC_LAMP_DIM2 && !light_on_cmd_in)
      |=> !lamp_on_out ##1 !pwm_out)
    else $error("fourth press did not turn the lamp off");
  a_open_cut_drive: assert property (
    open_cut |-> ##1 (!pwm_out && !lamp_on_out && open_fault_out))
    else $error("open string did not stop the drive stage");
  a_low_batt_show: assert property (
    (bat_valid && bat_low && en_reg[`SLC_EN_LOW_IND] && !low_battery_indicator_off_in)
      |=> ##1 low_battery_indicator_out)
    else $error("low battery indicator not lit below threshold");
  a_low_batt_cut: assert property (
    (bat_valid && bat_low) |=> ##1 !lamp_on_out ##1 !pwm_out)
    else $error("lamp not cut at low battery");
  a_overcharge_open: assert property (
    (bat_valid && bat_full) |=> ##1 !charge_switch_out)
    else $error("charging switch stayed closed at overcharge");
  a_light_off_cmd: assert property (
    light_off_cmd_in |=> !lamp_on_out ##1 !pwm_out)
    else $error("light-off command did not disable output");
endmodule

// [slc_defines.svh]
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH

// Conversion width of the current-sense and battery-divider samples.
`define SLC_ADC_W 10
// Channel code that a completed conversion carries.
`define SLC_CHAN_CURRENT 1'h0
`define SLC_CHAN_BATTERY 1'h1
// Samples per average, as a power of two.
`define SLC_AVG_SHIFT 4

// Clock rate and derived timing counts.
`define SLC_CLK_MHZ 20
`define SLC_DEBOUNCE_US 20000
`define SLC_BLINK_US 250000
`define SLC_DEBOUNCE_CYC (`SLC_DEBOUNCE_US * `SLC_CLK_MHZ)
`define SLC_BLINK_CYC (`SLC_BLINK_US * `SLC_CLK_MHZ)

// Intensity: duty = (W / (Vf * n)) * 5.6 / 0.00244, done in mW and mV.
`define SLC_OUT_MW 1000
`define SLC_LED_VF_MV 3200
`define SLC_LED_COUNT 3
`define SLC_INITIAL_DUTY ((`SLC_OUT_MW * 560000) / (`SLC_LED_VF_MV * `SLC_LED_COUNT * 244))
`define SLC_FIRST_DIM_DUTY 10'h0A0
`define SLC_SECOND_DIM_DUTY 10'h050

// Battery thresholds in averaged conversion counts.
`define SLC_LOW_BATT_TH 10'h200
`define SLC_OVERCHARGE_TH 10'h380
`define SLC_PHONE_CUT_TH 10'h260

// Reset values.
`define SLC_DUTY_RST 10'h000
`define SLC_ENABLES_RST 4'hF
// Bit positions in the manual enable vector.
`define SLC_EN_CHG_SW 0
`define SLC_EN_PHONE 1
`define SLC_EN_CHG_IND 2
`define SLC_EN_LOW_IND 3

`endif

// [slc_pkg.sv]
package slc_pkg;

  typedef enum logic [1:0] {
    SLC_LAMP_OFF = 2'b00,
    SLC_LAMP_FULL = 2'b01,
    SLC_LAMP_DIM1 = 2'b10,
    SLC_LAMP_DIM2 = 2'b11
  } slc_lamp_t;

endpackage

// [slc_in_filter.sv]
`timescale 1ns/1ps
module slc_in_filter #(
  parameter int DEBOUNCE_CYC = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic rise_reg;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  // A change is considered only once the second and third stages agree.
  wire agree = s2_reg == s3_reg;
  wire differs = agree && (s3_reg != level_reg);
  wire settled = differs && (cnt_reg >= 32'(DEBOUNCE_CYC - 1));
  assign cnt_next = (differs && !settled) ? 32'(cnt_reg + 32'h1) : 32'h0;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
      cnt_reg <= 32'h0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      cnt_reg <= cnt_next;
      rise_reg <= settled && s3_reg;
      if (settled) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_out = level_reg;
  assign rise_out = rise_reg;

  a_rise_single: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    rise_out |=> !rise_out)
    else $error("button press pulse lasted more than one cycle");
endmodule

// [slc_averager.sv]
`timescale 1ns/1ps
module slc_averager #(
  parameter int W = 10,
  parameter int SHIFT = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [W-1:0] sample_in,
  output logic avg_valid_out,
  output logic [W-1:0] avg_out
);
  logic [W+SHIFT-1:0] acc_reg;
  logic [SHIFT-1:0] cnt_reg;
  logic [W-1:0] avg_reg;
  logic valid_reg;

  // The accumulator is wide enough that a full block of samples never overflows.
  wire [W+SHIFT-1:0] sum = acc_reg + (W + SHIFT)'(sample_in);
  wire last = &cnt_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      avg_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (sample_valid_in) begin
        cnt_reg <= SHIFT'(cnt_reg + 1'b1);
        if (last) begin
          avg_reg <= sum[W+SHIFT-1:SHIFT];
          valid_reg <= 1'b1;
          acc_reg <= '0;
        end else begin
          acc_reg <= sum;
        end
      end
    end
  end

  assign avg_out = avg_reg;
  assign avg_valid_out = valid_reg;

  a_avg_after_block: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (sample_valid_in && last) |=> avg_valid_out)
    else $error("average missing after last sample of a block");
endmodule

// [slc_drive_model.sv]
`timescale 1ns/1ps
// Stands in for the sense resistor, battery divider and LED string. It delivers a
// burst of sixteen conversions on one channel and opens the string on command.
module slc_drive_model (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic chan_in,
  input wire logic [9:0] base_in,
  input wire logic [3:0] gap_in,
  input wire logic open_in,
  output logic adc_done_out,
  output logic adc_chan_out,
  output logic [9:0] adc_data_out,
  output logic led_open_out,
  output logic busy_out
);
  logic [3:0] cnt_reg;
  logic [3:0] wait_reg;
  logic chan_reg;
  logic issue;
  assign led_open_out = open_in;
  assign issue = busy_out && (wait_reg == 4'h0);
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
      adc_done_out <= 1'b0;
      cnt_reg <= 4'h0;
      wait_reg <= 4'h0;
    end else begin
      adc_done_out <= issue;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        chan_reg <= chan_in;
        cnt_reg <= 4'h0;
      end else if (busy_out && !issue) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (issue) begin
        cnt_reg <= cnt_reg + 4'h1;
        wait_reg <= gap_in;
        busy_out <= (cnt_reg != 4'hF);
      end
    end
  end
  // Between conversions the lines carry junk so that a stale sample cannot pass.
  always_ff @(posedge core_clk_in) begin
    adc_chan_out <= issue ? chan_reg : ~adc_chan_out;
    adc_data_out <= issue ? base_in + 10'(cnt_reg[1:0]) : ~adc_data_out;
  end
endmodule

// [slc_lamp_ctrl_tb.sv]
`timescale 1ns/1ps
`include "slc_defines.svh"
module slc_lamp_ctrl_tb;
  // Initial duty worked out from the wattage formula, kept apart from the design's integer form.
  localparam logic [9:0] INIT =
    10'($rtoi(5.6 * `SLC_OUT_MW / (`SLC_LED_VF_MV * `SLC_LED_COUNT) / 0.00244));
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic button = 1'b0;
  logic src = 1'b0;
  logic open_cmd = 1'b0;
  logic start = 1'b0;
  logic chan = 1'b0;
  logic [9:0] base = 10'h000;
  logic [9:0] cmd = 10'h000;
  logic [3:0] gap = 4'h0;
  logic adc_done, adc_chan, led_open, busy;
  logic [9:0] adc_data, duty, bv;
  logic pwm, lamp, fault, bvalid, csw, phone, cind, lbind;
  logic phone_n;
  logic [10:0] exp_q[$];
  logic [10:0] note;
  logic last_lamp = 1'b0;
  logic [9:0] last_duty = 10'h000;
  logic [9:0] v;
  int bad_count = 0;
  int comparisons = 0;
  int hi;

  always #25 core_clk_in = ~core_clk_in;

  slc_drive_model u_slc_drive_model (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .start_in(start), .chan_in(chan), .base_in(base), .gap_in(gap), .open_in(open_cmd),
    .adc_done_out(adc_done), .adc_chan_out(adc_chan), .adc_data_out(adc_data),
    .led_open_out(led_open), .busy_out(busy));

  slc_lamp_ctrl #(.DEBOUNCE_CYC(4), .BLINK_CYC(8)) u_slc_lamp_ctrl (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .adc_done_in(adc_done),
    .adc_chan_in(adc_chan), .adc_data_in(adc_data), .button_in(button),
    .led_open_in(led_open), .charge_source_in(src), .light_on_cmd_in(cmd[0]),
    .light_off_cmd_in(cmd[1]), .charge_switch_on_in(cmd[2]), .charge_switch_off_in(cmd[3]),
    .phone_charge_on_in(cmd[4]), .phone_charge_off_in(cmd[5]),
    .charge_indicator_on_in(cmd[6]), .charge_indicator_off_in(cmd[7]),
    .low_battery_indicator_on_in(cmd[8]), .low_battery_indicator_off_in(cmd[9]),
    .pwm_out(pwm), .lamp_on_out(lamp), .open_fault_out(fault), .duty_out(duty),
    .battery_volt_out(bv), .battery_valid_out(bvalid), .charge_switch_out(csw),
    .phone_charge_enable_out(phone), .charge_indicator_out(cind),
    .low_battery_indicator_out(lbind));

  // A second copy with the phone enable inverted, so that both polarities are seen.
  slc_lamp_ctrl #(.DEBOUNCE_CYC(4), .BLINK_CYC(8), .PHONE_ACTIVE_HIGH(1'b0)) u_slc_lamp_ctrl_low (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .adc_done_in(adc_done),
    .adc_chan_in(adc_chan), .adc_data_in(adc_data), .button_in(button),
    .led_open_in(led_open), .charge_source_in(src), .light_on_cmd_in(cmd[0]),
    .light_off_cmd_in(cmd[1]), .charge_switch_on_in(cmd[2]), .charge_switch_off_in(cmd[3]),
    .phone_charge_on_in(cmd[4]), .phone_charge_off_in(cmd[5]),
    .charge_indicator_on_in(cmd[6]), .charge_indicator_off_in(cmd[7]),
    .low_battery_indicator_on_in(cmd[8]), .low_battery_indicator_off_in(cmd[9]),
    .pwm_out(), .lamp_on_out(), .open_fault_out(), .duty_out(),
    .battery_volt_out(), .battery_valid_out(), .charge_switch_out(),
    .phone_charge_enable_out(phone_n), .charge_indicator_out(),
    .low_battery_indicator_out());

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (exp_q.size() != 0) bad_count++;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic burst(input logic c, input logic [9:0] b);
    int n;
    @(negedge core_clk_in);
    chan = c;
    base = b;
    gap = 4'($urandom % 4);
    start = 1'b1;
    @(negedge core_clk_in);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(negedge core_clk_in);
      n++;
    end
    repeat (6) @(negedge core_clk_in);
  endtask

  task automatic pulse(input int b);
    @(negedge core_clk_in);
    cmd[b] = 1'b1;
    @(negedge core_clk_in);
    cmd = 10'h000;
    repeat (3) @(negedge core_clk_in);
  endtask

  task automatic press;
    button = 1'b1;
    repeat (20) @(negedge core_clk_in);
    button = 1'b0;
    repeat (20) @(negedge core_clk_in);
  endtask

  task automatic count_high(output int n);
    n = 0;
    repeat (1024) begin
      @(negedge core_clk_in);
      if (pwm === 1'b1) n++;
    end
  endtask

  // Lamp state and duty are judged only when they move, against the oldest note.
  always @(negedge core_clk_in) begin
    if (!sys_rst_in && (lamp !== last_lamp || (lamp === 1'b1 && duty !== last_duty))) begin
      if (exp_q.size() == 0) begin
        check("unexpected lamp change", 16'h1, 16'h0);
      end else begin
        note = exp_q.pop_front();
        check("lamp on", 16'(lamp), 16'(note[10]));
        if (note[10]) check("duty", 16'(duty), 16'(note[9:0]));
      end
    end
    last_lamp = lamp;
    last_duty = duty;
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    bad_count++;
    test_done();
  end

  initial begin
    void'($urandom(32'h4A5E7C68));
    repeat (16) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    @(negedge core_clk_in);
    check("outputs after reset", 16'({pwm, lamp, fault, duty, phone}), 16'h0);
    check("inverted phone after reset", 16'(phone_n), 16'h1);
    src = 1'b1;
    burst(1'b1, 10'h2FF);
    check("battery volt", 16'(bv), 16'h0300);
    check("battery valid", 16'(bvalid), 16'h1);
    check("phone enable", 16'(phone), 16'h1);
    check("inverted phone enable", 16'(phone_n), 16'h0);
    check("charge switch", 16'(csw), 16'h1);
    check("low indicator", 16'(lbind), 16'h0);
    hi = 0;
    repeat (40) begin
      @(negedge core_clk_in);
      if (cind === 1'b1) hi++;
    end
    check("indicator blinks", 16'(hi > 0 && hi < 40), 16'h1);
    pulse(3);
    check("switch off", 16'(csw), 16'h0);
    pulse(2);
    check("switch on", 16'(csw), 16'h1);
    pulse(5);
    check("phone off", 16'(phone), 16'h0);
    check("inverted phone off", 16'(phone_n), 16'h1);
    pulse(4);
    check("phone on", 16'(phone), 16'h1);
    pulse(7);
    repeat (9) @(negedge core_clk_in);
    check("indicator off", 16'(cind), 16'h0);
    pulse(6);
    exp_q.push_back({1'b1, INIT});
    press();
    count_high(hi);
    check("pwm high cycles", 16'(hi), 16'(INIT));
    exp_q.push_back({1'b1, 10'(`SLC_FIRST_DIM_DUTY)});
    press();
    exp_q.push_back({1'b1, 10'(`SLC_SECOND_DIM_DUTY)});
    press();
    count_high(hi);
    check("dim pwm cycles", 16'(hi), 16'(`SLC_SECOND_DIM_DUTY));
    exp_q.push_back({1'b0, 10'h000});
    press();
    exp_q.push_back({1'b1, INIT});
    press();
    exp_q.push_back({1'b0, 10'h000});
    pulse(1);
    exp_q.push_back({1'b1, INIT});
    pulse(0);
    v = INIT - 10'h014 - 10'($urandom % 100);
    exp_q.push_back({1'b1, INIT + 10'h001});
    burst(1'b0, v);
    v = INIT + 10'h001 + 10'($urandom % 100);
    exp_q.push_back({1'b1, INIT});
    burst(1'b0, v);
    exp_q.push_back({1'b0, 10'h000});
    open_cmd = 1'b1;
    repeat (20) @(negedge core_clk_in);
    check("open fault", 16'(fault), 16'h1);
    check("pwm stopped", 16'(pwm), 16'h0);
    open_cmd = 1'b0;
    repeat (20) @(negedge core_clk_in);
    exp_q.push_back({1'b1, INIT});
    pulse(0);
    check("fault cleared", 16'(fault), 16'h0);
    exp_q.push_back({1'b0, 10'h000});
    burst(1'b1, 10'h0FF);
    check("low indicator", 16'(lbind), 16'h1);
    check("phone cut", 16'(phone), 16'h0);
    check("inverted phone cut", 16'(phone_n), 16'h1);
    pulse(9);
    check("low indicator off", 16'(lbind), 16'h0);
    pulse(8);
    check("low indicator on", 16'(lbind), 16'h1);
    pulse(0);
    check("lamp held off", 16'(lamp), 16'h0);
    burst(1'b1, 10'h39F);
    check("overcharge cut", 16'(csw), 16'h0);
    check("indicator steady", 16'(cind), 16'h1);
    repeat (12) @(negedge core_clk_in);
    check("indicator steady", 16'(cind), 16'h1);
    check("low indicator clear", 16'(lbind), 16'h0);
    repeat (10) @(negedge core_clk_in);
    test_done();
  end
endmodule
